// >>> prs_delay_timer.sv
`timescale 1ns/1ns
module prs_delay_timer #(
    parameter int CNT_W = 22
) (
    // Clock and reset
    input  wire logic               clk_in,
    input  wire logic               resetn_in,
    // Control
    input  wire logic               start_in,
    input  wire logic [CNT_W-1:0]   len_in,
    // Expiry pulse, len_in cycles after start_in is sampled
    output logic                    done_out
);

    logic [CNT_W-1:0] cnt_ff;
    logic             run_ff;
    logic             done_ff;

    // A new start simply reloads, so a stale expiry never leaks out
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
        end else if (start_in) begin
            cnt_ff <= len_in;
            run_ff <= 1'b1;
        end else if (run_ff) begin
            cnt_ff <= cnt_ff - 1'b1;
            run_ff <= (cnt_ff != 1);
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= run_ff && !start_in && (cnt_ff == 1);
        end
    end

    assign done_out = done_ff;

endmodule

// >>> prs_host_model.sv
`timescale 1ns/1ns
module prs_host_model (
    input  wire logic clk_in,
    input  wire logic echo_low_in,
    input  wire logic cmd_hold_in,
    input  wire logic cmd_lpr_in,
    input  wire logic auto_hold_in,
    input  wire logic slow_in,
    output logic      hold_out,
    output logic      lpr_out
);
    int   wait_cnt = 0;
    logic up_ff    = 1'b0;
    // Slow host still answers well inside the start-up sequence
    always @(negedge clk_in) begin
        if (!auto_hold_in) begin
            wait_cnt <= 0;
            up_ff <= 1'b0;
        end else if (echo_low_in || wait_cnt > 0) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == (slow_in ? 60 : 2))
                up_ff <= 1'b1;
        end
    end
    assign hold_out = cmd_hold_in | up_ff;
    assign lpr_out  = cmd_lpr_in;
endmodule

// >>> prs_pkg.sv
package prs_pkg;

    // Timebase
    localparam int CLK_MHZ = 100;

    // Sequence delays in microseconds, with their cycle counts at the clock rate
    localparam int T1_US    = 500;
    localparam int WAKE_US  = 100;
    localparam int T2_US    = 8000;
    localparam int T3_US    = 4000;
    localparam int T4_US    = 16000;
    localparam int TREC_US  = 32000;
    localparam int T1_CYC   = (T1_US + WAKE_US) * CLK_MHZ;
    localparam int T2_CYC   = T2_US * CLK_MHZ;
    localparam int T3_CYC   = T3_US * CLK_MHZ;
    localparam int T4_CYC   = T4_US * CLK_MHZ;
    localparam int TREC_CYC = TREC_US * CLK_MHZ;

    // Counter width that holds the longest delay
    localparam int CNT_W = 22;

    // Rail count and masks
    localparam int          NRAIL      = 3;
    localparam logic [2:0]  RAILS_NONE = 3'h0;
    localparam logic [2:0]  RAILS_B1   = 3'h1;
    localparam logic [2:0]  RAILS_B2   = 3'h2;
    localparam logic [2:0]  RAILS_B12  = 3'h3;
    localparam logic [2:0]  RAILS_ALL  = 3'h7;

    // Sequencer states, Gray coded along the start-up path
    typedef enum logic [3:0] {
        PRS_OFF     = 4'h0,
        PRS_WAIT_T1 = 4'h1,
        PRS_B1_UP   = 4'h3,
        PRS_WAIT_T2 = 4'h2,
        PRS_B2_UP   = 4'h6,
        PRS_WAIT_T3 = 4'h7,
        PRS_B3_UP   = 4'h5,
        PRS_WAIT_T4 = 4'h4,
        PRS_RUN     = 4'hc,
        PRS_HIB     = 4'hd
    } prs_state_t;

    // Reported power mode
    typedef enum logic [1:0] {
        PRS_MODE_OFF = 2'h0,
        PRS_MODE_HIB = 2'h1,
        PRS_MODE_LP  = 2'h3,
        PRS_MODE_ACT = 2'h2
    } prs_mode_t;

    // Host control pins travelling together through the synchroniser
    typedef struct packed {
        logic wake_n;
        logic hold;
        logic low_power;
    } prs_host_ctl_t;

    localparam prs_host_ctl_t HOST_CTL_IDLE = '{wake_n: 1'b1, hold: 1'b0, low_power: 1'b0};

endpackage

// >>> prs_sequencer.sv
`timescale 1ns/1ns
// Summary of operation
// - Reset output held low until start-up succeeds, released after final delay.
// - Undervoltage, system fault or buck overcurrent drops reset and rails at once.
// - Reset output is driven low in hibernate.
// - Button start needs button low throughout first delay; any high aborts.
// - Button toggling after step one is ignored, echo still follows.
// - Rising edge on hold input starts sequence; first delay 0.5 ms plus wake-up.
// - Start event invalid at first-delay expiry aborts before first buck.
// - Second buck enabled 8 ms after first buck is good.
// - Third buck enabled 4 ms after second buck is good.
// - All enabled rails checked before and after the 16 ms reset delay.
// - Hold low at reset release turns everything off, reset stays low.
// - Rail not good within 32 ms of enable aborts to off.
// - After reset release, hold and low-power request select power mode.
// - Rail in dropout bypass counts as good during start-up.
// - Hold falling with low-power low drops reset and turns all bucks off.
// - A buck turned off gets its discharge switch when discharge enabled.
// - Hold falling with low-power high keeps buck two, drops one and three.
// - Off, hibernate, low-power auto-skip, active forced PWM decode.
// - Echo output driven low while button detected low, else released.
// - Off is the initial state, left only through the start-up sequence.
module prs_sequencer #(
    parameter int unsigned T1_CYC   = prs_pkg::T1_CYC,
    parameter int unsigned T2_CYC   = prs_pkg::T2_CYC,
    parameter int unsigned T3_CYC   = prs_pkg::T3_CYC,
    parameter int unsigned T4_CYC   = prs_pkg::T4_CYC,
    parameter int unsigned TREC_CYC = prs_pkg::TREC_CYC,
    parameter int          CNT_W    = prs_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       resetn_in,
    // Host pins
    input  wire logic                       wake_button_n_in,
    input  wire logic                       hold_power_in,
    input  wire logic                       low_power_request_in,
    output logic                            host_reset_n_out,
    output logic                            host_reset_oe_out,
    output logic                            wake_echo_n_out,
    output logic                            wake_echo_oe_out,
    // Protection
    input  wire logic                       input_undervoltage_lockout_in,
    input  wire logic                       system_fault_in,
    input  wire logic [prs_pkg::NRAIL-1:0]  overcurrent_in,
    // Rail monitors and controls
    input  wire logic [prs_pkg::NRAIL-1:0]  rail_good_in,
    input  wire logic [prs_pkg::NRAIL-1:0]  rail_bypass_in,
    input  wire logic [prs_pkg::NRAIL-1:0]  discharge_enable_in,
    output logic [prs_pkg::NRAIL-1:0]       buck_enable_out,
    output logic [prs_pkg::NRAIL-1:0]       forced_pulse_width_mode_out,
    output logic [prs_pkg::NRAIL-1:0]       discharge_on_out,
    // Status
    output prs_pkg::prs_mode_t              power_mode_out
);

    if (CNT_W < 2 || CNT_W > 31 || T1_CYC < 1 || T2_CYC < 1 || T3_CYC < 1 || T4_CYC < 1
            || TREC_CYC < 1 || TREC_CYC >= (1 << CNT_W) || T4_CYC >= (1 << CNT_W)
            || T2_CYC >= (1 << CNT_W) || T1_CYC >= (1 << CNT_W)
            || T3_CYC >= (1 << CNT_W)) begin : g_bad_params
        $error("prs_sequencer: delay counts do not fit the counter");
    end

    // Rails that each state keeps enabled
    function automatic logic [2:0] rails_of(input prs_pkg::prs_state_t st, input logic skip);
        logic [2:0] r;
        r = prs_pkg::RAILS_NONE;
        case (st)
            prs_pkg::PRS_WAIT_T1: r = skip ? prs_pkg::RAILS_B2 : prs_pkg::RAILS_NONE;
            prs_pkg::PRS_B1_UP,
            prs_pkg::PRS_WAIT_T2: r = skip ? prs_pkg::RAILS_B12 : prs_pkg::RAILS_B1;
            prs_pkg::PRS_B2_UP,
            prs_pkg::PRS_WAIT_T3: r = prs_pkg::RAILS_B12;
            prs_pkg::PRS_B3_UP,
            prs_pkg::PRS_WAIT_T4,
            prs_pkg::PRS_RUN:     r = prs_pkg::RAILS_ALL;
            prs_pkg::PRS_HIB:     r = prs_pkg::RAILS_B2;
            default:              r = prs_pkg::RAILS_NONE;
        endcase
        return r;
    endfunction

    // Host pins come from another domain
    prs_pkg::prs_host_ctl_t host_raw;
    prs_pkg::prs_host_ctl_t host_s;

    assign host_raw.wake_n    = wake_button_n_in;
    assign host_raw.hold      = hold_power_in;
    assign host_raw.low_power = low_power_request_in;

    prs_sync2 #(
        .W       (3),
        .RST_VAL (prs_pkg::HOST_CTL_IDLE)
    ) u_host_sync (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .d_in      (host_raw),
        .q_out     (host_s)
    );

    logic btn_low;
    logic hold_s;
    logic lpr_s;

    assign btn_low = !host_s.wake_n;
    assign hold_s  = host_s.hold;
    assign lpr_s   = host_s.low_power;

    // Edge history
    logic hold_prev_ff;
    logic btn_prev_ff;

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            hold_prev_ff <= 1'b0;
            btn_prev_ff  <= 1'b0;
        end else begin
            hold_prev_ff <= hold_s;
            btn_prev_ff  <= btn_low;
        end
    end

    logic hold_rise;
    logic btn_fall;
    logic fault_any;

    assign hold_rise = hold_s && !hold_prev_ff;
    assign btn_fall  = btn_low && !btn_prev_ff;
    assign fault_any = input_undervoltage_lockout_in || system_fault_in || (|overcurrent_in);

    // Sequencer state
    prs_pkg::prs_state_t state_ff;
    prs_pkg::prs_state_t nxt_state;
    logic                src_btn_ff;
    logic                nxt_src_btn;
    logic                skip_ff;
    logic                nxt_skip;
    logic                tmr_start;
    logic [CNT_W-1:0]    tmr_len;
    logic                tmr_done;

    prs_delay_timer #(
        .CNT_W (CNT_W)
    ) u_timer (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .start_in  (tmr_start),
        .len_in    (tmr_len),
        .done_out  (tmr_done)
    );

    // Good, or in dropout bypass, for every rail now enabled
    logic [2:0] rail_ok;
    logic       all_ok;

    assign rail_ok = rail_good_in | rail_bypass_in;
    assign all_ok  = (rails_of(state_ff, skip_ff) & ~rail_ok) == prs_pkg::RAILS_NONE;

    always_comb begin
        nxt_state   = state_ff;
        nxt_src_btn = src_btn_ff;
        nxt_skip    = skip_ff;
        tmr_start   = 1'b0;
        tmr_len     = '0;
        if (fault_any) begin
            nxt_state = prs_pkg::PRS_OFF;
        end else begin
            case (state_ff)
                prs_pkg::PRS_OFF: begin
                    // Off is left only by a start event
                    if (hold_rise || btn_fall) begin
                        nxt_state   = prs_pkg::PRS_WAIT_T1;
                        nxt_src_btn = !hold_rise;
                        nxt_skip    = 1'b0;
                        tmr_start   = 1'b1;
                        tmr_len     = CNT_W'(T1_CYC);
                    end
                end
                prs_pkg::PRS_WAIT_T1: begin
                    if (src_btn_ff && !btn_low) begin
                        nxt_state = prs_pkg::PRS_OFF;
                    end else if (tmr_done) begin
                        if (src_btn_ff ? btn_low : hold_s) begin
                            nxt_state = prs_pkg::PRS_B1_UP;
                            tmr_start = 1'b1;
                            tmr_len   = CNT_W'(TREC_CYC);
                        end else begin
                            nxt_state = prs_pkg::PRS_OFF;
                        end
                    end
                end
                prs_pkg::PRS_B1_UP: begin
                    // Button no longer looked at from here on
                    if (rail_ok[0]) begin
                        nxt_state = skip_ff ? prs_pkg::PRS_WAIT_T3 : prs_pkg::PRS_WAIT_T2;
                        tmr_start = 1'b1;
                        tmr_len   = skip_ff ? CNT_W'(T3_CYC) : CNT_W'(T2_CYC);
                    end else if (tmr_done) begin
                        nxt_state = prs_pkg::PRS_OFF;
                    end
                end
                prs_pkg::PRS_WAIT_T2: begin
                    if (tmr_done) begin
                        nxt_state = prs_pkg::PRS_B2_UP;
                        tmr_start = 1'b1;
                        tmr_len   = CNT_W'(TREC_CYC);
                    end
                end
                prs_pkg::PRS_B2_UP: begin
                    if (rail_ok[1]) begin
                        nxt_state = prs_pkg::PRS_WAIT_T3;
                        tmr_start = 1'b1;
                        tmr_len   = CNT_W'(T3_CYC);
                    end else if (tmr_done) begin
                        nxt_state = prs_pkg::PRS_OFF;
                    end
                end
                prs_pkg::PRS_WAIT_T3: begin
                    if (tmr_done) begin
                        nxt_state = prs_pkg::PRS_B3_UP;
                        tmr_start = 1'b1;
                        tmr_len   = CNT_W'(TREC_CYC);
                    end
                end
                prs_pkg::PRS_B3_UP: begin
                    if (all_ok) begin
                        nxt_state = prs_pkg::PRS_WAIT_T4;
                        tmr_start = 1'b1;
                        tmr_len   = CNT_W'(T4_CYC);
                    end else if (tmr_done) begin
                        nxt_state = prs_pkg::PRS_OFF;
                    end
                end
                prs_pkg::PRS_WAIT_T4: begin
                    if (tmr_done) begin
                        if (all_ok && hold_s) begin
                            nxt_state = prs_pkg::PRS_RUN;
                        end else begin
                            nxt_state = prs_pkg::PRS_OFF;
                        end
                    end
                end
                prs_pkg::PRS_RUN: begin
                    if (!hold_s) begin
                        nxt_state = lpr_s ? prs_pkg::PRS_HIB : prs_pkg::PRS_OFF;
                    end
                end
                prs_pkg::PRS_HIB: begin
                    // Restart keeps buck two running and skips its step
                    if (hold_rise) begin
                        nxt_state   = prs_pkg::PRS_WAIT_T1;
                        nxt_src_btn = 1'b0;
                        nxt_skip    = 1'b1;
                        tmr_start   = 1'b1;
                        tmr_len     = CNT_W'(T1_CYC);
                    end else if (!lpr_s) begin
                        nxt_state = prs_pkg::PRS_OFF;
                    end
                end
                default: begin
                    nxt_state = prs_pkg::PRS_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state_ff   <= prs_pkg::PRS_OFF;
            src_btn_ff <= 1'b0;
            skip_ff    <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            src_btn_ff <= nxt_src_btn;
            skip_ff    <= nxt_skip;
        end
    end

    // Rail, reset and mode outputs follow the next state so they move in the same cycle as the state; echo follows the button
    logic [2:0]         buck_ff;
    logic [2:0]         forced_pulse_width_mode_ff;
    logic [2:0]         disch_ff;
    logic               rst_oe_ff;
    logic               echo_oe_ff;
    prs_pkg::prs_mode_t mode_ff;
    logic [2:0]         nxt_rails;

    assign nxt_rails = rails_of(nxt_state, nxt_skip);

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            buck_ff  <= prs_pkg::RAILS_NONE;
            disch_ff <= prs_pkg::RAILS_NONE;
        end else begin
            buck_ff  <= nxt_rails;
            disch_ff <= ~nxt_rails & discharge_enable_in;
        end
    end

    // Reset only ever rises on entry to run, so an aborted release cannot glitch
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_oe_ff <= 1'b1;
        end else begin
            rst_oe_ff <= (nxt_state != prs_pkg::PRS_RUN);
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            echo_oe_ff <= 1'b0;
        end else begin
            echo_oe_ff <= btn_low;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            forced_pulse_width_mode_ff <= prs_pkg::RAILS_NONE;
            mode_ff <= prs_pkg::PRS_MODE_OFF;
        end else begin
            case (nxt_state)
                prs_pkg::PRS_OFF: begin
                    forced_pulse_width_mode_ff <= prs_pkg::RAILS_NONE;
                    mode_ff <= prs_pkg::PRS_MODE_OFF;
                end
                prs_pkg::PRS_HIB: begin
                    forced_pulse_width_mode_ff <= prs_pkg::RAILS_NONE;
                    mode_ff <= prs_pkg::PRS_MODE_HIB;
                end
                prs_pkg::PRS_RUN: begin
                    forced_pulse_width_mode_ff <= lpr_s ? prs_pkg::RAILS_NONE : prs_pkg::RAILS_ALL;
                    mode_ff <= lpr_s ? prs_pkg::PRS_MODE_LP : prs_pkg::PRS_MODE_ACT;
                end
                default: begin
                    forced_pulse_width_mode_ff <= nxt_rails;
                    mode_ff <= prs_pkg::PRS_MODE_OFF;
                end
            endcase
        end
    end

    assign buck_enable_out             = buck_ff;
    assign discharge_on_out            = disch_ff;
    assign forced_pulse_width_mode_out = forced_pulse_width_mode_ff;
    assign power_mode_out              = mode_ff;
    assign host_reset_oe_out           = rst_oe_ff;
    assign wake_echo_oe_out            = echo_oe_ff;
    // Open-drain pins only ever pull low
    assign host_reset_n_out            = 1'b0;
    assign wake_echo_n_out             = 1'b0;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    a_fault_drops_all: assert property (fault_any |=> host_reset_oe_out && buck_enable_out == 3'h0)
        else $error("fault did not drop reset and rails");
    a_release_only_t4: assert property ($fell(host_reset_oe_out) |-> $past(state_ff) == prs_pkg::PRS_WAIT_T4 && $past(tmr_done) && $past(hold_s))
        else $error("reset released outside final delay expiry");
    a_hib_reset_low: assert property (state_ff == prs_pkg::PRS_HIB |-> host_reset_oe_out && buck_enable_out == 3'h2 && forced_pulse_width_mode_out == 3'h0)
        else $error("hibernate outputs wrong");
    a_btn_high_abort: assert property (state_ff == prs_pkg::PRS_WAIT_T1 && src_btn_ff && !btn_low |=> state_ff == prs_pkg::PRS_OFF && buck_enable_out == 3'h0)
        else $error("button release did not abort");
    a_echo_follows: assert property (btn_low |=> wake_echo_oe_out ##0 (!btn_low) [*2] |=> !wake_echo_oe_out)
        else $error("echo does not follow button");
    a_b2_after_t2: assert property ($rose(buck_enable_out[1]) |-> $past(state_ff) == prs_pkg::PRS_WAIT_T2 || $past(state_ff) == prs_pkg::PRS_RUN || $past(state_ff) == prs_pkg::PRS_OFF)
        else $error("buck two enabled out of turn");
    a_hold_low_off: assert property (state_ff == prs_pkg::PRS_WAIT_T4 && tmr_done && !hold_s && !fault_any |=> state_ff == prs_pkg::PRS_OFF && host_reset_oe_out)
        else $error("release with hold low");
    a_pwr_down: assert property (state_ff == prs_pkg::PRS_RUN && !hold_s && !lpr_s |=> host_reset_oe_out && buck_enable_out == 3'h0)
        else $error("power-down did not turn rails off");
    a_discharge_off: assert property (##1 discharge_on_out == (~buck_enable_out & $past(discharge_enable_in)))
        else $error("discharge does not match off rails");
    a_recover_abort: assert property (state_ff == prs_pkg::PRS_B1_UP && tmr_done && !rail_ok[0] |=> state_ff == prs_pkg::PRS_OFF)
        else $error("failed rail did not abort");
    a_t1_expiry_check: assert property (state_ff == prs_pkg::PRS_WAIT_T1 && tmr_done && !src_btn_ff && !hold_s && !fault_any |=> buck_enable_out[0] == 1'b0)
        else $error("first buck started on stale event");

    c_reach_run: cover property (state_ff == prs_pkg::PRS_WAIT_T4 ##1 state_ff == prs_pkg::PRS_RUN);
    c_reach_hib: cover property (state_ff == prs_pkg::PRS_RUN ##1 state_ff == prs_pkg::PRS_HIB);
    c_hib_restart: cover property (state_ff == prs_pkg::PRS_HIB ##1 state_ff == prs_pkg::PRS_WAIT_T1);
    c_recover_abort: cover property (state_ff == prs_pkg::PRS_B2_UP ##1 state_ff == prs_pkg::PRS_OFF);

endmodule

// >>> prs_sync2.sv
`timescale 1ns/1ns
module prs_sync2 #(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    // Clock and reset
    input  wire logic           clk_in,
    input  wire logic           resetn_in,
    // Data
    input  wire logic [W-1:0]   d_in,
    output logic [W-1:0]        q_out
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // First stage is read only by the second
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_ff <= RST_VAL;
            q_ff    <= RST_VAL;
        end else begin
            meta_ff <= d_in;
            q_ff    <= meta_ff;
        end
    end

    assign q_out = q_ff;

endmodule

// >>> test_power_rail_sequencer.sv
`timescale 1ns/1ns
module test_power_rail_sequencer;
    logic clk_in = 1'b0, resetn_in = 1'b0, btn_n = 1'b1, input_undervoltage_lockout = 1'b0, sysf = 1'b0;
    logic cmd_hold = 1'b0, cmd_lpr = 1'b0, auto_h = 1'b0, slow = 1'b0;
    logic [2:0] oc = 3'h0, good_m = 3'h7, byp = 3'h0, dis_en = 3'h0;
    logic hold, lpr, rst_oe, echo_oe, rst_d, echo_d;
    logic [2:0] buck, forced_pulse_width_mode, dis_on;
    prs_pkg::prs_mode_t mode;
    logic [3:0] exp_q[$];
    logic [3:0] std_q[4] = '{4'h9, 4'hb, 4'hf, 4'h7};
    logic [3:0] last = 4'h8, e;
    int bad_count = 0, checked = 0, seed = 32'h314460fc;

    always #5 clk_in = ~clk_in;

    // Short delays keep the run brief; the sequence order is unchanged
    prs_sequencer #(.T1_CYC(20), .T2_CYC(30), .T3_CYC(40), .T4_CYC(50), .TREC_CYC(100)) i_dut (
        .clk_in(clk_in), .resetn_in(resetn_in),
        .wake_button_n_in(btn_n), .hold_power_in(hold), .low_power_request_in(lpr),
        .host_reset_n_out(rst_d), .host_reset_oe_out(rst_oe),
        .wake_echo_n_out(echo_d), .wake_echo_oe_out(echo_oe),
        .input_undervoltage_lockout_in(input_undervoltage_lockout), .system_fault_in(sysf), .overcurrent_in(oc),
        .rail_good_in(buck & good_m), .rail_bypass_in(byp), .discharge_enable_in(dis_en),
        .buck_enable_out(buck), .forced_pulse_width_mode_out(forced_pulse_width_mode),
        .discharge_on_out(dis_on), .power_mode_out(mode));

    prs_host_model i_host (
        .clk_in(clk_in), .echo_low_in(echo_oe), .cmd_hold_in(cmd_hold), .cmd_lpr_in(cmd_lpr),
        .auto_hold_in(auto_h), .slow_in(slow), .hold_out(hold), .lpr_out(lpr));

    task automatic summarize();
        $display("bad_count=%0d checked=%0d", bad_count, checked);
        if (bad_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [7:0] ex, input logic [7:0] got);
        checked++;
        if (got !== ex) begin
            bad_count++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, ex, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_in);
    endtask

    task automatic seq(input int a, input int b, input logic [3:0] tail);
        for (int i = a; i < b; i++)
            exp_q.push_back(std_q[i]);
        if (tail != 4'h0)
            exp_q.push_back(tail);
    endtask

    task automatic wait_q(input int m);
        int k;
        k = 0;
        while (exp_q.size() > m && k < 3000) begin
            cyc(1);
            k++;
        end
        chk(8'h0, 8'(k / 3000));
    endtask

    task automatic drain();
        wait_q(0);
        cyc(5);
    endtask

    task automatic hold_run(input int n);
        seq(0, n, 4'h8);
        cmd_hold = 1'b1;
        wait_q(1);
    endtask

    // Every change of reset or rail enables must match the oldest note
    always @(posedge clk_in) begin
        #1;
        if ({rst_oe, buck} !== last) begin
            last = {rst_oe, buck};
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 4'hx;
            chk({4'h0, e}, {4'h0, last});
        end
    end

    initial begin
        #1000000;
        bad_count++;
        summarize();
    end

    initial begin
        cyc(10);
        resetn_in = 1'b1;
        cyc(3);
        seq(0, 4, 4'h0);
        cmd_hold = 1'b1;
        drain();
        chk(8'h2, {6'h0, mode});
        chk(8'h7, {5'h0, forced_pulse_width_mode});
        cmd_lpr = 1'b1;
        cyc(5);
        chk(8'h3, {6'h0, mode});
        chk(8'h0, {5'h0, forced_pulse_width_mode});
        exp_q.push_back(4'ha);
        cmd_hold = 1'b0;
        drain();
        chk(8'h1, {6'h0, mode});
        seq(1, 4, 4'h0);
        cmd_hold = 1'b1;
        cmd_lpr = 1'b0;
        drain();
        dis_en = 3'($random(seed));
        exp_q.push_back(4'h8);
        cmd_hold = 1'b0;
        drain();
        chk({5'h0, dis_en}, {5'h0, dis_on});
        for (int k = 0; k < 3; k++) begin
            hold_run(4);
            input_undervoltage_lockout = (k == 0);
            sysf = (k == 1);
            oc = (k == 2) ? 3'(2 << ($random(seed) & 1)) : 3'h0;
            cyc(1);
            {input_undervoltage_lockout, sysf, oc} = 5'h0;
            cmd_hold = 1'b0;
            drain();
        end
        good_m = 3'h3;
        hold_run(3);
        drain();
        cmd_hold = 1'b0;
        cyc(5);
        byp = 3'h4;
        hold_run(4);
        cmd_hold = 1'b0;
        drain();
        {good_m, byp} = 6'h38;
        for (int s = 0; s < 2; s++) begin
            auto_h = 1'b1;
            slow = s[0];
            seq(0, 4, 4'h8);
            btn_n = 1'b0;
            cyc(30);
            btn_n = 1'b1;
            cyc(15);
            btn_n = 1'b0;
            cyc(5);
            chk(8'h1, {7'h0, echo_oe});
            chk(8'h0, {6'h0, rst_d, echo_d});
            btn_n = 1'b1;
            wait_q(1);
            auto_h = 1'b0;
            drain();
        end
        seq(0, 3, 4'h8);
        btn_n = 1'b0;
        cyc(30);
        btn_n = 1'b1;
        drain();
        btn_n = 1'b0;
        cyc(2 + ($random(seed) & 15));
        btn_n = 1'b1;
        cyc(40);
        chk(8'h8, {4'h0, rst_oe, buck});
        summarize();
    end
endmodule
